//--- hdl/lpwq_defs.svh
`ifndef LPWQ_DEFS_SVH
`define LPWQ_DEFS_SVH

// Register byte offsets on the Wishbone slave.
`define LPWQ_CTRL_OFS 8'h00
`define LPWQ_CMD_OFS 8'h04
`define LPWQ_STAT_OFS 8'h08

// Fields of the control register (low_power_control_reg0).
`define LPWQ_CTRL_RST 32'h0000_0000
`define LPWQ_F_PRD_LSB 0
`define LPWQ_F_SIX 8
`define LPWQ_F_QEN 9
`define LPWQ_F_DIV_LSB 10
`define LPWQ_F_STBY 12
`define LPWQ_F_FSLEEP 13
`define LPWQ_F_SVC 14
`define LPWQ_F_SQC_LSB 16

// Timing counts in system clock cycles.
`define LPWQ_IDLE_FAST_CYC 11'h014
`define LPWQ_IDLE_SLOW_CYC 11'h41A
`define LPWQ_STBY_FAST_CYC 11'h064
`define LPWQ_STBY_SLOW_CYC 11'h465
`define LPWQ_HOLD_16_CYC 7'h10
`define LPWQ_HOLD_32_CYC 7'h20
`define LPWQ_HOLD_64_CYC 7'h40
`define LPWQ_XCLK_LOW_CYC 7'h28

// Timing counts in oscillator clock cycles.
`define LPWQ_GUARD_OSC 3'h4
`define LPWQ_SWAKE_RAW_OSC 7'h03
`define LPWQ_SWAKE_BASE_OSC 7'h02

`endif

//--- hdl/lpwq_pkg.sv
package lpwq_pkg;
  typedef enum logic [2:0] {
    LPWQ_RUN = 3'b000,
    LPWQ_IDLE = 3'b001,
    LPWQ_SHOLD = 3'b010,
    LPWQ_STBY = 3'b011,
    LPWQ_WAKE = 3'b100
  } lpwq_state_t;
endpackage : lpwq_pkg

//--- hdl/lpwq_top.sv
// Notes on behaviour
// RULE1 - The qualifier samples every cycle when the period field is zero, otherwise every twice that field value cycles.
// RULE2 - Validity is judged from 3 or 6 consecutive samples as the sample select bit chooses.
// RULE3 - In three-sample mode the window spans two sampling periods.
// RULE4 - In six-sample mode the window spans five sampling periods.
// RULE5 - The qualified level changes only when every sample of the window agrees, else it holds.
// RULE6 - An idle wake line must stay active 2 cycles raw, or 5 cycles plus the window when qualified.
// RULE7 - After an idle wake execution resumes within 20 cycles, or 1050 with a sleeping flash.
// RULE8 - The wake latency ends at the resume of the instruction after entry; servicing costs more.
// RULE9 - Idle is left by an enabled interrupt, the watchdog, the non-maskable input or the reset pin.
// RULE10 - No wake may start before 4 oscillator cycles have passed since entry.
// RULE11 - A standby wake must last 3 oscillator cycles raw, or 2 plus the 6-bit count when qualified.
// RULE12 - On standby entry the external clock output goes low 32 to 45 cycles after entry.
// RULE13 - After a standby wake execution resumes within 100 cycles, or 1125 with a sleeping flash.
// RULE14 - On standby entry the system clock runs on 16, 32 or 64 cycles by divider select.
// RULE15 - Software enters standby from on-chip RAM with no external bus access pending.
// RULE16 - In standby the peripheral clocks stop while the PLL and watchdog keep running.
// RULE17 - After standby the device resumes and services the waking interrupt when enabled.
`timescale 1ns/1ps
`include "lpwq_defs.svh"

module lpwq_top
  import lpwq_pkg::*;
#(
  parameter int ADR_W = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Wake sources and oscillator tick.
  input wire logic wake_pin_i,
  input wire logic int_wake_i,
  input wire logic watchdog_interrupt_i,
  input wire logic external_nmi_input_i,
  input wire logic device_reset_pin_n_i,
  input wire logic osc_tick_i,
  // Qualified level, clock and resume controls.
  output logic qual_o,
  output logic system_clock_run_o,
  output logic periph_clk_en_o,
  output logic pll_run_o,
  output logic wdog_run_o,
  output logic external_clock_output_o,
  output logic cpu_resume_o,
  output logic service_int_o
);

  lpwq_state_t state_ff, nxt_state;
  logic [31:0] ctrl_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [5:0] samp_ff;
  logic [8:0] div_cnt_ff;
  logic qual_ff;
  logic [2:0] guard_ff;
  logic [6:0] wlen_ff;
  logic [6:0] hold_ff;
  logic [6:0] ent_ff;
  logic [10:0] lat_ff;
  logic [10:0] lat_max_ff;
  logic run_ff, xstop_ff, xclk_ff, resume_ff, svc_ff, src_int_ff;

  // Bus decode.
  wire req = wb_cyc_i && wb_stb_i;
  wire acc = req && ack_ff;
  wire [7:0] adr8 = 8'(wb_adr_i);
  wire hit_ctrl = adr8 == `LPWQ_CTRL_OFS;
  wire hit_cmd = adr8 == `LPWQ_CMD_OFS;
  wire hit_stat = adr8 == `LPWQ_STAT_OFS;
  wire go = acc && wb_we_i && hit_cmd && wb_sel_i[0] && wb_dat_i[0];
  wire [31:0] stat_w = {24'h000000, 1'b0, xstop_ff, run_ff, src_int_ff,
                        qual_ff, state_ff};
  wire [31:0] rmux = hit_ctrl ? ctrl_ff : (hit_stat ? stat_w : 32'h00000000);

  // Control fields.
  wire [7:0] prd = ctrl_ff[`LPWQ_F_PRD_LSB +: 8];
  wire six = ctrl_ff[`LPWQ_F_SIX];
  wire qen = ctrl_ff[`LPWQ_F_QEN];
  wire [1:0] dsel = ctrl_ff[`LPWQ_F_DIV_LSB +: 2];
  wire stby_mode = ctrl_ff[`LPWQ_F_STBY];
  wire fsleep = ctrl_ff[`LPWQ_F_FSLEEP];
  wire svc_en = ctrl_ff[`LPWQ_F_SVC];
  wire [5:0] sqc = ctrl_ff[`LPWQ_F_SQC_LSB +: 6];

  // Input qualifier.
  wire [8:0] period = {prd, 1'b0};
  wire samp_tick = (prd == 8'h00) || (div_cnt_ff >= period - 9'h001); // RULE1
  wire agree3 = (&samp_ff[2:0]) || (~|samp_ff[2:0]); // RULE3
  wire agree6 = (&samp_ff) || (~|samp_ff); // RULE4
  wire agree = six ? agree6 : agree3; // RULE2
  wire nxt_qual = agree ? samp_ff[0] : qual_ff; // RULE5

  // Wake detection.
  wire pin_wake = qen ? qual_ff : wake_pin_i;
  wire wake_any = pin_wake || int_wake_i || watchdog_interrupt_i ||
                  external_nmi_input_i || !device_reset_pin_n_i; // RULE9
  wire guard_ok = guard_ff == `LPWQ_GUARD_OSC; // RULE10
  wire [6:0] sthr = qen ? (`LPWQ_SWAKE_BASE_OSC + {1'b0, sqc})
                        : `LPWQ_SWAKE_RAW_OSC;
  wire idle_hit = state_ff == LPWQ_IDLE && guard_ok && wake_any;
  wire stby_hit = state_ff == LPWQ_STBY && guard_ok && wlen_ff >= sthr; // RULE11
  wire wake_hit = idle_hit || stby_hit;
  wire [6:0] hold_n = dsel == 2'b11 ? `LPWQ_HOLD_64_CYC
                    : (dsel == 2'b10 ? `LPWQ_HOLD_32_CYC
                    : `LPWQ_HOLD_16_CYC); // RULE14
  wire hold_done = state_ff == LPWQ_SHOLD && hold_ff == hold_n - 7'h01;
  wire [10:0] lat_n = idle_hit
    ? (fsleep ? `LPWQ_IDLE_SLOW_CYC : `LPWQ_IDLE_FAST_CYC) // RULE7
    : (fsleep ? `LPWQ_STBY_SLOW_CYC : `LPWQ_STBY_FAST_CYC); // RULE13
  wire lat_done = state_ff == LPWQ_WAKE && lat_ff == lat_max_ff - 11'h002;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LPWQ_RUN: begin
        if (go) begin
          nxt_state = stby_mode ? LPWQ_SHOLD : LPWQ_IDLE;
        end
      end
      LPWQ_IDLE: begin
        if (idle_hit) begin
          nxt_state = LPWQ_WAKE;
        end
      end
      LPWQ_SHOLD: begin
        if (hold_done) begin
          nxt_state = LPWQ_STBY;
        end
      end
      LPWQ_STBY: begin
        if (stby_hit) begin
          nxt_state = LPWQ_WAKE;
        end
      end
      LPWQ_WAKE: begin
        if (lat_done) begin
          nxt_state = LPWQ_RUN;
        end
      end
      default: begin
        nxt_state = LPWQ_RUN;
      end
    endcase
  end

  // Control register, one generate step per byte lane; sample shift stages 1 to 5.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctrl_ff[8*gi +: 8] <= 8'(`LPWQ_CTRL_RST >> (8*gi));
        end else if (acc && wb_we_i && hit_ctrl && wb_sel_i[gi]) begin
          ctrl_ff[8*gi +: 8] <= wb_dat_i[8*gi +: 8];
        end
      end
    end
    for (gi = 1; gi < 6; gi++) begin : g_samp
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          samp_ff[gi] <= 1'b0;
        end else if (samp_tick) begin
          samp_ff[gi] <= samp_ff[gi-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req && !ack_ff;
      rdat_ff <= (req && !ack_ff && !wb_we_i) ? rmux : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samp_ff[0] <= 1'b0;
      div_cnt_ff <= 9'h000;
      qual_ff <= 1'b0;
    end else begin
      samp_ff[0] <= samp_tick ? wake_pin_i : samp_ff[0];
      div_cnt_ff <= samp_tick ? 9'h000 : div_cnt_ff + 9'h001;
      qual_ff <= nxt_qual;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff == LPWQ_RUN || state_ff == LPWQ_WAKE) begin
      guard_ff <= 3'h0;
    end else if (osc_tick_i && !guard_ok) begin
      guard_ff <= guard_ff + 3'h1; // RULE10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !wake_any || state_ff != LPWQ_STBY) begin
      wlen_ff <= 7'h00;
    end else if (osc_tick_i && wlen_ff != 7'h7F) begin
      wlen_ff <= wlen_ff + 7'h01; // RULE11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= LPWQ_RUN;
      hold_ff <= 7'h00;
      ent_ff <= 7'h00;
      lat_ff <= 11'h000;
      lat_max_ff <= `LPWQ_IDLE_FAST_CYC;
      src_int_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      hold_ff <= state_ff == LPWQ_SHOLD ? hold_ff + 7'h01 : 7'h00;
      if (go) begin
        ent_ff <= 7'h00;
      end else if (ent_ff != 7'h7F) begin
        ent_ff <= ent_ff + 7'h01;
      end
      lat_ff <= state_ff == LPWQ_WAKE ? lat_ff + 11'h001 : 11'h000;
      if (wake_hit) begin
        lat_max_ff <= lat_n;
        src_int_ff <= int_wake_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_ff <= 1'b1;
      xstop_ff <= 1'b0;
      xclk_ff <= 1'b0;
      resume_ff <= 1'b0;
      svc_ff <= 1'b0;
    end else begin
      if (hold_done) begin
        run_ff <= 1'b0; // RULE14
      end else if (wake_hit) begin
        run_ff <= 1'b1;
      end
      if ((state_ff == LPWQ_SHOLD || state_ff == LPWQ_STBY) &&
          ent_ff == `LPWQ_XCLK_LOW_CYC - 7'h01) begin
        xstop_ff <= 1'b1; // RULE12
      end else if (wake_hit) begin
        xstop_ff <= 1'b0;
      end
      xclk_ff <= xstop_ff ? 1'b0 : !xclk_ff;
      resume_ff <= lat_done; // RULE8
      svc_ff <= lat_done && src_int_ff && svc_en; // RULE17
    end
  end

  // Outputs.
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign qual_o = qual_ff;
  assign system_clock_run_o = run_ff;
  assign periph_clk_en_o = run_ff; // RULE16
  assign pll_run_o = 1'b1; // RULE16
  assign wdog_run_o = 1'b1; // RULE16
  assign external_clock_output_o = xclk_ff;
  assign cpu_resume_o = resume_ff;
  assign service_int_o = svc_ff;

  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [8:0] gap_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || samp_tick) begin
      gap_ff <= 9'h000;
    end else begin
      gap_ff <= gap_ff + 9'h001;
    end
  end

  // Marks a sample interval in which the period field was rewritten.
  logic prd_chg_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || samp_tick) begin
      prd_chg_ff <= 1'b0;
    end else if ($changed(prd)) begin
      prd_chg_ff <= 1'b1;
    end
  end

  sequence stby_go_s;
    go && stby_mode && state_ff == LPWQ_RUN;
  endsequence

  sample_gap_a: assert property (samp_tick && $stable(prd) && !prd_chg_ff && prd != 8'h00 && $past(samp_tick) == 1'b0 |-> gap_ff == period - 9'h001) else $error("Sample spacing wrong."); // RULE1
  qual_agree_a: assert property ($changed(qual_ff) |-> $past(agree)) else $error("Qualified level changed without agreement."); // RULE5
  six_window_a: assert property (six && $stable(six) && $changed(qual_ff) |-> $past(agree6)) else $error("Six-sample window not honoured."); // RULE4
  xclk_low_a: assert property (stby_go_s |-> ##[32:45] !xclk_ff ##1 !xclk_ff) else $error("External clock not low in time."); // RULE12
  hold_64_a: assert property (stby_go_s and dsel == 2'b11 |-> ##64 run_ff ##1 !run_ff) else $error("Clock hold is not 64 cycles."); // RULE14
  hold_16_a: assert property (stby_go_s and dsel[1] == 1'b0 |-> ##16 run_ff ##1 !run_ff) else $error("Clock hold is not 16 cycles."); // RULE14
  idle_resume_a: assert property (idle_hit && !fsleep |-> ##[1:20] resume_ff) else $error("Idle resume too late."); // RULE7
  stby_resume_a: assert property (stby_hit && !fsleep |-> ##[1:100] resume_ff) else $error("Standby resume too late."); // RULE13
  nmi_wake_a: assert property (state_ff == LPWQ_IDLE && guard_ok && external_nmi_input_i |=> state_ff == LPWQ_WAKE) else $error("Non-maskable wake ignored."); // RULE9
  stby_clocks_a: assert property (state_ff == LPWQ_STBY |-> !periph_clk_en_o && pll_run_o && wdog_run_o) else $error("Standby clock state wrong."); // RULE16
  stby_pulse_a: assert property (state_ff == LPWQ_STBY ##1 state_ff == LPWQ_WAKE |-> $past(wlen_ff) >= $past(sthr)) else $error("Standby wake too short."); // RULE11
  service_a: assert property (resume_ff |-> svc_ff == ($past(src_int_ff) && $past(svc_en))) else $error("Service pulse wrong."); // RULE17

endmodule : lpwq_top

//--- testbench/lpwq_wake_src.sv
`timescale 1ns/1ps
module lpwq_wake_src (
  // Clock and request from the bench.
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [2:0] src_i,
  input wire logic [7:0] len_i,
  // Status.
  output logic busy_o,
  output logic act_o,
  // Wake lines and oscillator tick.
  output logic osc_tick_o,
  output logic wake_pin_o,
  output logic int_o,
  output logic wdog_o,
  output logic nmi_o,
  output logic rst_n_o
);
  logic [1:0] div_ff = 2'h0;
  logic [2:0] tick_ff = 3'h0;
  logic [7:0] len_ff = 8'h00;
  logic [2:0] src_ff = 3'h0;
  initial busy_o = 1'b0;
  initial act_o = 1'b0;
  always @(posedge clk_i) begin
    div_ff <= div_ff + 2'h1;
    if (go_i) begin
      busy_o <= 1'b1;
      tick_ff <= 3'h0;
      len_ff <= len_i;
      src_ff <= src_i;
    end else if (busy_o && !act_o) begin
      if (osc_tick_o) tick_ff <= tick_ff + 3'h1;
      if (tick_ff == 3'h4) act_o <= 1'b1;
    end else if (act_o) begin
      len_ff <= len_ff - 8'h01;
      if (len_ff == 8'h01) begin
        act_o <= 1'b0;
        busy_o <= 1'b0;
      end
    end
  end
  assign osc_tick_o = (div_ff == 2'h3);
  assign wake_pin_o = act_o && (src_ff == 3'h0);
  assign int_o = act_o && (src_ff == 3'h1);
  assign wdog_o = act_o && (src_ff == 3'h2);
  assign nmi_o = act_o && (src_ff == 3'h3);
  assign rst_n_o = !(act_o && (src_ff == 3'h4));
endmodule : lpwq_wake_src

//--- testbench/test_low_power_wake_and_input_qualifier.sv
`timescale 1ns/1ps
`include "lpwq_defs.svh"
module test_low_power_wake_and_input_qualifier;
  import lpwq_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0;
  logic [7:0] adr = 8'h00, len = 8'h00, prd;
  logic [2:0] src = 3'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ack_o, qual, clk_run, periph, pll, wdog, xclk, resume, svc;
  logic busy, act, tick, w_pin, w_int, w_wd, w_nmi, w_rst_n;
  logic qseen = 0, svcs = 0, xbad = 0, xchk = 0;
  int error_cnt = 0, tests_run = 0, cyc_cnt = 0;
  int t_e, t_w = -1, t_res = -1, t_fall = -1, n, per, hold;
  integer seed = 32'had489bde;
  lpwq_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
    .wake_pin_i(w_pin), .int_wake_i(w_int), .watchdog_interrupt_i(w_wd),
    .external_nmi_input_i(w_nmi), .device_reset_pin_n_i(w_rst_n),
    .osc_tick_i(tick), .qual_o(qual), .system_clock_run_o(clk_run),
    .periph_clk_en_o(periph), .pll_run_o(pll), .wdog_run_o(wdog),
    .external_clock_output_o(xclk), .cpu_resume_o(resume),
    .service_int_o(svc));
  lpwq_wake_src src_u (.clk_i(clk_i), .go_i(go), .src_i(src), .len_i(len),
    .busy_o(busy), .act_o(act), .osc_tick_o(tick), .wake_pin_o(w_pin),
    .int_o(w_int), .wdog_o(w_wd), .nmi_o(w_nmi), .rst_n_o(w_rst_n));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (act === 1'b1 && t_w < 0) t_w <= cyc_cnt;
    if (resume === 1'b1) t_res <= cyc_cnt;
    if (svc === 1'b1) svcs <= 1'b1;
    if (qual === 1'b1) qseen <= 1'b1;
    if (clk_run !== 1'b1 && t_fall < 0) t_fall <= cyc_cnt;
    if (xchk && cyc_cnt >= t_e + 45 && xclk !== 1'b0) xbad <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int v, input int lo, input int hi,
                         input string m);
    tests_run++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0d not in %0d..%0d", $time, m, v, lo, hi);
    end
  endtask : chk_rng
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rdat = dat_o;
    t_e = cyc_cnt;
    chk({31'h0, ack_o}, 32'h1, "ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic fire(input logic [2:0] s, input logic [7:0] l);
    t_w = -1;
    t_res = -1;
    svcs = 0;
    src <= s;
    len <= l;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < 300 && busy; k++) @(posedge clk_i);
  endtask : fire
  task automatic wait_res(input int lim);
    for (int k = 0; k < lim && t_res < 0; k++) @(posedge clk_i);
  endtask : wait_res
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, `LPWQ_CTRL_OFS, 32'h0);
    chk(rdat, `LPWQ_CTRL_RST, "ctrl reset");
    wb(0, `LPWQ_STAT_OFS, 32'h0);
    chk(rdat, 32'h0000_0020, "stat reset");
    wb(1, 8'h0C, 32'hFFFF_FFFF);
    wb(0, 8'h0C, 32'h0);
    chk(rdat, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      prd = (i < 2) ? 8'h00 : 8'(($random(seed) & 3) + 1);
      n = (i % 2) ? 6 : 3;
      per = (prd == 8'h00) ? 1 : 2 * prd;
      wb(1, `LPWQ_CTRL_OFS, 32'(prd) | 32'((i % 2) << 8));
      for (int k = 0; k < 2; k++) begin
        qseen = 0;
        fire(0, (prd == 8'h00) ? 8'(n - 1 + k) :
             (k ? 8'(per * (n + 1) + 2) : 8'h01));
        repeat (per * (n + 1) + 5) @(posedge clk_i);
        chk(qseen, k, "qualifier");
        repeat (per * (n + 2) + 5) @(posedge clk_i);
      end
    end
    for (int s = 0; s < 5; s++) begin
      wb(1, `LPWQ_CTRL_OFS, 32'h0000_4000);
      wb(1, `LPWQ_CMD_OFS, 32'h1);
      fire(3'(s), 8'h02);
      wait_res(60);
      chk_rng(t_res - t_w, 20, 24, "idle latency");
      chk(svcs, s == 1, "service");
    end
    wb(1, `LPWQ_CTRL_OFS, 32'h0000_2000);
    wb(1, `LPWQ_CMD_OFS, 32'h1);
    fire(1, 8'h02);
    wait_res(1100);
    chk_rng(t_res - t_w, 1050, 1054, "sleep latency");
    for (int d = 0; d < 4; d++) begin
      hold = (d < 2) ? 16 : 16 << (d - 1);
      wb(1, `LPWQ_CTRL_OFS, 32'h1000 | (d << 10) | (d == 1 ? 32'h50200 : 0));
      t_fall = -1;
      xbad = 0;
      wb(1, `LPWQ_CMD_OFS, 32'h1);
      xchk = 1;
      repeat (hold + 50) @(posedge clk_i);
      chk(t_fall - t_e, hold + 1, "clock hold");
      chk({periph, pll, wdog}, 32'h3, "clocks");
      xchk = 0;
      chk(xbad, 0, "xclk low");
      if (d < 2) begin
        fire(1, (d == 0) ? 8'h01 : 8'h10);
        repeat (150) @(posedge clk_i);
        chk(t_res, -1, "short wake");
      end
      len = (d == 1) ? 8'd40 : 8'd16;
      fire(2, len);
      wait_res(250);
      chk_rng(t_res - t_w, 100, 112 + len, "stby latency");
      chk(clk_run, 1, "clock back");
    end
    give_verdict();
  end
endmodule : test_low_power_wake_and_input_qualifier
